// [csw_pkg.sv]
// package of offsets, field positions and constants for the status word bank
package csw_pkg;
  // ---------------------------------------------------------------
  // word offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_MAJOR_FAULT_CODE = 8'h06;
  localparam logic [7:0] OFS_SUSPEND_CODE = 8'h07;
  localparam logic [7:0] OFS_SUSPEND_FILE = 8'h08;
  localparam logic [7:0] OFS_ACTIVE_NODES_LOW = 8'h09;
  localparam logic [7:0] OFS_ACTIVE_NODES_HIGH = 8'h0A;
  localparam logic [7:0] OFS_MATH_RESULT_LOW = 8'h0D;
  localparam logic [7:0] OFS_MATH_RESULT_HIGH = 8'h0E;
  localparam logic [7:0] OFS_NODE_AND_LINK_RATE = 8'h0F;
  localparam logic [7:0] OFS_MAX_SCAN_TIME = 8'h16;
  localparam logic [7:0] OFS_FAULT_ROUTINE_FILE = 8'h1D;
  localparam logic [7:0] OFS_TIMED_IRQ_SETPOINT = 8'h1E;
  localparam logic [7:0] OFS_TIMED_IRQ_FILE = 8'h1F;
  localparam logic [7:0] OFS_CHANNEL0_LINK_FLAGS = 8'h21;
  // ---------------------------------------------------------------
  // field positions and limits
  // ---------------------------------------------------------------
  localparam int CH0_MIRROR_BITS = 5;
  localparam int SCAN_TOGGLE_POS = 9;
  localparam logic [15:0] MAX_SCAN_LIMIT = 16'h7FFF;
  localparam logic [7:0] FILE_NUMBER_LIMIT = 8'hFF;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] WORD_RESET = 16'h0000;
  // ---------------------------------------------------------------
  // timing: one scan-time unit of 100 us at a 50 ns clock
  // ---------------------------------------------------------------
  localparam int SCAN_UNIT_NS = 100000;
  localparam int CLK_PERIOD_NS = 50;
  localparam int SCAN_UNIT_CYCLES = SCAN_UNIT_NS / CLK_PERIOD_NS;
  // ---------------------------------------------------------------
  // access source
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    CSW_SRC_LADDER = 2'h1,
    CSW_SRC_MESSAGE = 2'h2
  } csw_src_t;
endpackage : csw_pkg

// [csw_status_bank.sv]
// status word bank with fault, suspend, math, scan and link mirrors
//
// Operation
// - read/write major error word names last fault
// - suspend instruction stores signed suspend code
// - suspend instruction stores suspend file 0..255
// - two read-only active-node words mirror channel
// - mirrored words refuse message-path access
// - math pair updates on math instructions
// - low byte mirrors node address
// - high byte mirrors baud rate code
// - end of scan keeps larger scan time
// - scan time in 100 us units, max 32767
// - fault routine file selects user fault subroutine
// - timed interrupt set point read-only mirror
// - timed interrupt file read-only mirror
// - channel-0 bits 0..4 mirror status
// - scan toggle inverts at each scan end not shared with mode entry
// - toggle cleared on entry to executing mode
`timescale 1ns/10ps
module csw_status_bank #(
  parameter int UNIT_CYCLES = csw_pkg::SCAN_UNIT_CYCLES
) (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_clk_en,
  // word access port
  input wire logic i_acc_valid,
  input wire logic i_acc_write,
  input wire csw_pkg::csw_src_t i_acc_src,
  input wire logic [7:0] i_acc_addr,
  input wire logic [15:0] i_acc_wdata,
  output logic [15:0] o_acc_rdata,
  output logic o_acc_done,
  output logic o_acc_refused,
  // instruction and scan events
  input wire logic i_fault_valid,
  input wire logic [15:0] i_fault_code,
  input wire logic i_suspend_instruction,
  input wire logic [15:0] i_suspend_code,
  input wire logic [7:0] i_suspend_file,
  input wire logic i_math_valid,
  input wire logic [31:0] i_math_result,
  input wire logic i_scan_end,
  input wire logic i_enter_exec,
  input wire logic i_user_fault,
  // mirrored sources
  input wire logic [15:0] i_active_nodes_low,
  input wire logic [15:0] i_active_nodes_high,
  input wire logic [15:0] i_channel_status_word5,
  input wire logic [15:0] i_channel0_status_word4,
  input wire logic [15:0] i_interrupt_setpoint_field,
  input wire logic [15:0] i_interrupt_program_file_field,
  input wire logic [7:0] i_fault_routine_cfg,
  // user fault dispatch
  output logic o_user_fault_call,
  output logic [7:0] o_user_fault_file
);
  import csw_pkg::*;

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [15:0] major_fault_code;
  logic [15:0] suspend_code;
  logic [7:0] suspend_file;
  logic [15:0] math_result_low;
  logic [15:0] math_result_high;
  logic [15:0] max_scan_time;
  // read-only copies of outside fields, then scan toggle and scan counters
  logic [15:0] active_nodes_low;
  logic [15:0] active_nodes_high;
  logic [15:0] node_and_link_rate;
  logic [15:0] timed_irq_setpoint;
  logic [15:0] timed_irq_file;
  logic [7:0] fault_routine_file;
  logic [CH0_MIRROR_BITS-1:0] channel0_flags;
  logic scan_toggle;
  logic [31:0] unit_count;
  logic [15:0] scan_units;

  logic wr_ladder;
  logic [15:0] next_scan_units;
  logic [15:0] next_rdata;

  // ladder-path writes only
  assign wr_ladder = i_acc_valid && i_acc_write && (i_acc_src == CSW_SRC_LADDER);

  // ---------------------------------------------------------------
  // fault and suspend capture
  // ---------------------------------------------------------------
  // hardware fault capture wins over a same-cycle user write
  // no clear path: the last cause stays until overwritten
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      major_fault_code <= WORD_RESET;
    end else if (i_clk_en) begin
      if (i_fault_valid) begin
        major_fault_code <= i_fault_code;
      end else if (wr_ladder && i_acc_addr == OFS_MAJOR_FAULT_CODE) begin
        major_fault_code <= i_acc_wdata;
      end
    end
  end

  // suspend code, never cleared by hardware
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      suspend_code <= WORD_RESET;
    end else if (i_clk_en) begin
      if (i_suspend_instruction) begin
        suspend_code <= i_suspend_code;
      end else if (wr_ladder && i_acc_addr == OFS_SUSPEND_CODE) begin
        suspend_code <= i_acc_wdata;
      end
    end
  end

  // suspend file, 0..255, never cleared by hardware
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      suspend_file <= WORD_RESET[7:0];
    end else if (i_clk_en) begin
      if (i_suspend_instruction) begin
        suspend_file <= i_suspend_file;
      end else if (wr_ladder && i_acc_addr == OFS_SUSPEND_FILE) begin
        suspend_file <= i_acc_wdata[7:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // math register pair
  // ---------------------------------------------------------------
  // low word takes bits 15:0; held until the next math op or ladder write
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      math_result_low <= WORD_RESET;
    end else if (i_clk_en) begin
      if (i_math_valid) begin
        math_result_low <= i_math_result[15:0];
      end else if (wr_ladder && i_acc_addr == OFS_MATH_RESULT_LOW) begin
        math_result_low <= i_acc_wdata;
      end
    end
  end

  // high word takes bits 31:16 on the same edge as the low word
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      math_result_high <= WORD_RESET;
    end else if (i_clk_en) begin
      if (i_math_valid) begin
        math_result_high <= i_math_result[31:16];
      end else if (wr_ladder && i_acc_addr == OFS_MATH_RESULT_HIGH) begin
        math_result_high <= i_acc_wdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // scan time measurement
  // ---------------------------------------------------------------
  // saturating units counter, restarted at every scan end
  assign next_scan_units = (scan_units == MAX_SCAN_LIMIT) ? scan_units : scan_units + 16'h0001;

  // count whole 100 us units; a partial unit is dropped (-1 to +0)
  // mode entry restarts the count so the first scan is measured whole
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      unit_count <= 32'h0000_0000;
      scan_units <= WORD_RESET;
    end else if (i_clk_en) begin
      if (i_scan_end || i_enter_exec) begin
        unit_count <= 32'h0000_0000;
        scan_units <= WORD_RESET;
      end else if (unit_count == 32'(UNIT_CYCLES - 1)) begin
        unit_count <= 32'h0000_0000;
        scan_units <= next_scan_units;
      end else begin
        unit_count <= unit_count + 32'h0000_0001;
      end
    end
  end

  // keep the largest scan seen; user write stands until a larger scan
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      max_scan_time <= WORD_RESET;
    end else if (i_clk_en) begin
      if (i_scan_end && scan_units > max_scan_time) begin
        max_scan_time <= scan_units;
      end else if (wr_ladder && i_acc_addr == OFS_MAX_SCAN_TIME) begin
        max_scan_time <= i_acc_wdata & MAX_SCAN_LIMIT;
      end
    end
  end

  // ---------------------------------------------------------------
  // scan toggle
  // ---------------------------------------------------------------
  // entry into executing mode beats the scan-end inversion
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      scan_toggle <= 1'b0;
    end else if (i_clk_en) begin
      if (i_enter_exec) begin
        scan_toggle <= 1'b0;
      end else if (i_scan_end) begin
        scan_toggle <= ~scan_toggle;
      end else if (wr_ladder && i_acc_addr == OFS_CHANNEL0_LINK_FLAGS) begin
        scan_toggle <= i_acc_wdata[SCAN_TOGGLE_POS];
      end
    end
  end

  // ---------------------------------------------------------------
  // read-only mirrors
  // ---------------------------------------------------------------
  // active-node words, one edge behind the channel status file
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      active_nodes_low <= WORD_RESET;
      active_nodes_high <= WORD_RESET;
    end else if (i_clk_en) begin
      active_nodes_low <= i_active_nodes_low;
      active_nodes_high <= i_active_nodes_high;
    end
  end

  // node address in the low byte, baud rate code in the high byte
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      node_and_link_rate <= WORD_RESET;
    end else if (i_clk_en) begin
      node_and_link_rate[7:0] <= i_channel_status_word5[7:0];
      node_and_link_rate[15:8] <= i_channel_status_word5[15:8];
    end
  end

  // timed-interrupt set point and file number copies
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      timed_irq_setpoint <= WORD_RESET;
      timed_irq_file <= WORD_RESET;
    end else if (i_clk_en) begin
      timed_irq_setpoint <= i_interrupt_setpoint_field;
      timed_irq_file <= i_interrupt_program_file_field;
    end
  end

  // user fault routine file, read-only to the access port
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      fault_routine_file <= WORD_RESET[7:0];
    end else if (i_clk_en) begin
      fault_routine_file <= i_fault_routine_cfg & FILE_NUMBER_LIMIT;
    end
  end

  // channel-0 link flags, bits 4:0 only
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      channel0_flags <= '0;
    end else if (i_clk_en) begin
      channel0_flags <= i_channel0_status_word4[CH0_MIRROR_BITS-1:0];
    end
  end

  // ---------------------------------------------------------------
  // user fault dispatch
  // ---------------------------------------------------------------
  // one-cycle call pulse for each user fault
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_user_fault_call <= 1'b0;
    end else if (i_clk_en) begin
      o_user_fault_call <= i_user_fault;
    end
  end

  // subroutine file latched with the call, held between faults
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_user_fault_file <= WORD_RESET[7:0];
    end else if (i_clk_en && i_user_fault) begin
      o_user_fault_file <= fault_routine_file;
    end
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  // word select; unmapped offsets read zero
  // read-only words have no write decode, so writes to them fall away
  always_comb begin
    next_rdata = WORD_RESET;
    unique case (i_acc_addr)
      OFS_MAJOR_FAULT_CODE: next_rdata = major_fault_code;
      OFS_SUSPEND_CODE: next_rdata = suspend_code;
      OFS_SUSPEND_FILE: next_rdata = {8'h00, suspend_file};
      OFS_ACTIVE_NODES_LOW: next_rdata = active_nodes_low;
      OFS_ACTIVE_NODES_HIGH: next_rdata = active_nodes_high;
      OFS_MATH_RESULT_LOW: next_rdata = math_result_low;
      OFS_MATH_RESULT_HIGH: next_rdata = math_result_high;
      OFS_NODE_AND_LINK_RATE: next_rdata = node_and_link_rate;
      OFS_MAX_SCAN_TIME: next_rdata = max_scan_time;
      OFS_FAULT_ROUTINE_FILE: next_rdata = {8'h00, fault_routine_file};
      OFS_TIMED_IRQ_SETPOINT: next_rdata = timed_irq_setpoint;
      OFS_TIMED_IRQ_FILE: next_rdata = timed_irq_file;
      OFS_CHANNEL0_LINK_FLAGS: begin
        next_rdata[CH0_MIRROR_BITS-1:0] = channel0_flags;
        next_rdata[SCAN_TOGGLE_POS] = scan_toggle;
      end
      default: next_rdata = WORD_RESET;
    endcase
  end

  // done pulses one edge after each access, refusal one edge after each non-ladder access
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_acc_done <= 1'b0;
      o_acc_refused <= 1'b0;
    end else if (i_clk_en) begin
      o_acc_done <= i_acc_valid;
      o_acc_refused <= i_acc_valid && (i_acc_src != CSW_SRC_LADDER);
    end
  end

  // read data for ladder reads; writes and message accesses answer zero
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_acc_rdata <= WORD_RESET;
    end else if (i_clk_en) begin
      if (i_acc_valid && !i_acc_write && i_acc_src == CSW_SRC_LADDER) begin
        o_acc_rdata <= next_rdata;
      end else if (i_acc_valid) begin
        o_acc_rdata <= WORD_RESET;
      end
    end
  end

endmodule : csw_status_bank

// [csw_status_bank_asserts.sv]
// port checks for the status word bank
`timescale 1ns/10ps
module csw_status_bank_asserts (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_clk_en,
  input wire logic i_acc_valid,
  input wire logic i_acc_write,
  input wire csw_pkg::csw_src_t i_acc_src,
  input wire logic [7:0] i_acc_addr,
  input wire logic [15:0] o_acc_rdata,
  input wire logic o_acc_refused,
  input wire logic i_user_fault,
  input wire logic [15:0] i_active_nodes_low,
  input wire logic [15:0] i_channel0_status_word4,
  input wire logic [7:0] i_fault_routine_cfg,
  input wire logic o_user_fault_call,
  input wire logic [7:0] o_user_fault_file
);
  import csw_pkg::*;
  logic run;
  wire logic acc = i_clk_en && i_acc_valid;
  wire logic rd = acc && !i_acc_write && i_acc_src == CSW_SRC_LADDER && run;
  // high from the first edge after reset, once mirrors hold input values
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) run <= 1'b0;
    else run <= 1'b1;
  end
  // -------------
  // assertions
  // -------------
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_reset_n);
  property p_msg_refused; acc && i_acc_src != CSW_SRC_LADDER
    |=> o_acc_refused && o_acc_rdata == 16'h0000; endproperty
  a_msg_refused: assert property (p_msg_refused) else $error("message access served");
  property p_ladder_served; acc && i_acc_src == CSW_SRC_LADDER |=> !o_acc_refused; endproperty
  a_ladder_served: assert property (p_ladder_served) else $error("ladder refused");
  property p_refused_cause; o_acc_refused
    |-> $past(i_acc_valid) && $past(i_acc_src) != CSW_SRC_LADDER; endproperty
  a_refused_cause: assert property (p_refused_cause) else $error("refusal uncaused");
  property p_nodes_low; rd && i_acc_addr == OFS_ACTIVE_NODES_LOW
    && $stable(i_active_nodes_low) |=> o_acc_rdata == $past(i_active_nodes_low); endproperty
  a_nodes_low: assert property (p_nodes_low) else $error("node word mirror wrong");
  property p_ch0_bits; rd && i_acc_addr == OFS_CHANNEL0_LINK_FLAGS
    && $stable(i_channel0_status_word4)
    |=> (o_acc_rdata & 16'hFDFF) == ($past(i_channel0_status_word4) & 16'h001F); endproperty
  a_ch0_bits: assert property (p_ch0_bits) else $error("channel flags wrong");
  property p_call; i_clk_en && i_user_fault && run && $stable(i_fault_routine_cfg)
    |=> o_user_fault_call && o_user_fault_file == $past(i_fault_routine_cfg, 2); endproperty
  a_call: assert property (p_call) else $error("fault routine call wrong");
  property p_call_cause; o_user_fault_call |-> $past(i_user_fault); endproperty
  a_call_cause: assert property (p_call_cause) else $error("call uncaused");
  property p_call_once; o_user_fault_call && !i_user_fault |=> !o_user_fault_call; endproperty
  a_call_once: assert property (p_call_once) else $error("call too long");
endmodule : csw_status_bank_asserts

// [csw_status_bank_test.sv]
// self-checking testbench for the status word bank
`timescale 1ns/10ps
module csw_status_bank_test;
  import csw_pkg::*;
  // -------------
  // signals
  // -------------
  localparam int UNITS = 4;
  localparam logic [15:0] TGL = 16'h0001 << SCAN_TOGGLE_POS;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic en = 1'b1;
  logic v = 1'b0;
  logic wr = 1'b0;
  csw_src_t src = CSW_SRC_LADDER;
  logic [7:0] ad = 8'h00;
  logic [7:0] sfile = 8'h00;
  logic [7:0] cfg = 8'h00;
  logic [15:0] wd = 16'h0000;
  logic [15:0] code = 16'h0000;
  logic [31:0] math = 32'h0000_0000;
  logic [15:0] mir [6] = '{default: 16'h0000};
  logic [5:0] ev = 6'h00; // user fault, enter exec, scan end, math, suspend, fault
  logic [15:0] rdt;
  logic dn;
  logic rf;
  logic call;
  logic [7:0] file;
  int error_cnt = 0;
  int num_checks = 0;
  // design and clock
  csw_status_bank #(.UNIT_CYCLES(UNITS)) csw_status_bank_inst (
    .i_core_clk(clk), .i_reset_n(rst_n), .i_clk_en(en), .i_acc_valid(v),
    .i_acc_write(wr), .i_acc_src(src), .i_acc_addr(ad), .i_acc_wdata(wd),
    .o_acc_rdata(rdt), .o_acc_done(dn), .o_acc_refused(rf), .i_fault_valid(ev[0]),
    .i_fault_code(code), .i_suspend_instruction(ev[1]), .i_suspend_code(code),
    .i_suspend_file(sfile), .i_math_valid(ev[2]), .i_math_result(math),
    .i_scan_end(ev[3]), .i_enter_exec(ev[4]), .i_user_fault(ev[5]),
    .i_active_nodes_low(mir[0]), .i_active_nodes_high(mir[1]),
    .i_channel_status_word5(mir[2]), .i_channel0_status_word4(mir[3]),
    .i_interrupt_setpoint_field(mir[4]), .i_interrupt_program_file_field(mir[5]),
    .i_fault_routine_cfg(cfg), .o_user_fault_call(call), .o_user_fault_file(file));
  always #25 clk = ~clk;
  // -------------
  // tasks
  // -------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=0x%h exp=0x%h", $time, seen, exp);
    end
  endtask : check
  task automatic acc(input logic w, input csw_src_t s, input logic [7:0] a,
      input logic [15:0] d);
    @(posedge clk);
    v <= 1'b1;
    wr <= w;
    src <= s;
    ad <= a;
    wd <= d;
    @(posedge clk);
    v <= 1'b0;
    #1;
    check({15'h0000, dn}, 16'h0001);
    check({15'h0000, rf}, {15'h0000, s != CSW_SRC_LADDER});
  endtask : acc
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    acc(1'b0, CSW_SRC_LADDER, a, 16'h0000);
    check(rdt, e);
  endtask : rd
  task automatic tgl(input logic e);
    acc(1'b0, CSW_SRC_LADDER, OFS_CHANNEL0_LINK_FLAGS, 16'h0000);
    check(rdt & TGL, e ? TGL : 16'h0000);
  endtask : tgl
  task automatic pulse(input logic [5:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 6'h00;
  endtask : pulse
  task automatic t_words();
    logic [7:0] a [9] = '{OFS_MAJOR_FAULT_CODE, OFS_SUSPEND_CODE, OFS_SUSPEND_FILE,
        OFS_MATH_RESULT_LOW, OFS_MATH_RESULT_HIGH, OFS_MAX_SCAN_TIME, OFS_ACTIVE_NODES_LOW,
        OFS_FAULT_ROUTINE_FILE, 8'h00};
    logic [15:0] e [9] = '{16'hB6C9, 16'hB6C9, 16'h00C9, 16'hB6C9, 16'hB6C9,
        16'hB6C9 & MAX_SCAN_LIMIT, 16'h0000, 16'h0000, 16'h0000};
    foreach (a[i]) rd(a[i], WORD_RESET);
    foreach (a[i]) acc(1'b1, CSW_SRC_LADDER, a[i], 16'hB6C9);
    foreach (a[i]) rd(a[i], e[i]);
  endtask : t_words
  task automatic t_mirrors();
    logic [7:0] a [7] = '{OFS_ACTIVE_NODES_LOW, OFS_ACTIVE_NODES_HIGH, OFS_NODE_AND_LINK_RATE,
        OFS_FAULT_ROUTINE_FILE, OFS_TIMED_IRQ_SETPOINT, OFS_TIMED_IRQ_FILE,
        OFS_CHANNEL0_LINK_FLAGS};
    logic [15:0] e [7] = '{16'h1357, 16'h2468, 16'hA1B2, 16'h005A, 16'hFEDC, 16'h0102,
        16'h000A};
    @(posedge clk);
    mir <= '{16'h1357, 16'h2468, 16'hA1B2, 16'hFDEA, 16'hFEDC, 16'h0102};
    cfg <= 8'h5A;
    foreach (a[i]) rd(a[i], e[i]);
    foreach (a[i]) begin
      acc(1'b0, CSW_SRC_MESSAGE, a[i], 16'h0000);
      check(rdt, 16'h0000);
    end
    acc(1'b1, CSW_SRC_MESSAGE, OFS_MAJOR_FAULT_CODE, 16'h1234);
    rd(OFS_MAJOR_FAULT_CODE, 16'hB6C9);
    pulse(6'h20);
    #1;
    check({7'h00, call, file}, 16'h015A);
    @(posedge clk);
    #1;
    check({15'h0000, call}, 16'h0000);
  endtask : t_mirrors
  task automatic t_events();
    @(posedge clk);
    code <= 16'h0D21;
    pulse(6'h01);
    code <= 16'h8000;
    sfile <= 8'hFF;
    math <= 32'h89AB_CDEF;
    pulse(6'h06);
    code <= 16'h0000;
    sfile <= 8'h00;
    math <= 32'h0000_0000;
    pulse(6'h08);
    rd(OFS_MAJOR_FAULT_CODE, 16'h0D21);
    rd(OFS_SUSPEND_CODE, 16'h8000);
    rd(OFS_SUSPEND_FILE, 16'h00FF);
    rd(OFS_MATH_RESULT_LOW, 16'hCDEF);
    rd(OFS_MATH_RESULT_HIGH, 16'h89AB);
  endtask : t_events
  // fault and scan end while the clock enable is low must leave all state alone
  task automatic t_freeze();
    @(posedge clk);
    en <= 1'b0;
    code <= 16'h7E57;
    pulse(6'h09);
    @(posedge clk);
    en <= 1'b1;
    rd(OFS_MAJOR_FAULT_CODE, 16'h0D21);
    tgl(1'b1);
  endtask : t_freeze
  task automatic t_scan();
    acc(1'b1, CSW_SRC_LADDER, OFS_MAX_SCAN_TIME, 16'h0000);
    pulse(6'h10);
    repeat (UNITS * 5) @(posedge clk);
    pulse(6'h08);
    repeat (UNITS * 2) @(posedge clk);
    pulse(6'h08);
    rd(OFS_MAX_SCAN_TIME, 16'h0005);
    tgl(1'b0);
    pulse(6'h08);
    tgl(1'b1);
    pulse(6'h10);
    tgl(1'b0);
    pulse(6'h08);
    pulse(6'h18);
    tgl(1'b0);
    pulse(6'h10);
    repeat (UNITS * 7) @(posedge clk);
    pulse(6'h08);
    rd(OFS_MAX_SCAN_TIME, 16'h0007);
  endtask : t_scan
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test
  // main sequence
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_words();
    t_mirrors();
    t_events();
    t_freeze();
    t_scan();
    finish_test();
  end
endmodule : csw_status_bank_test
bind csw_status_bank csw_status_bank_asserts csw_status_bank_asserts_inst (.*);
